// ==== dv/ict_cclk_src.sv ====
`default_nettype none

module ict_cclk_src (
  input  wire logic i_clk,
  input  wire logic i_run,
  input  wire logic i_gate_req,
  output logic      o_cclk,
  output logic      o_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph;

  initial begin
    o_cclk = 1'b0;
    o_gate = 1'b0;
    ph = 1'b0;
  end

  // count clock of four system cycles, parked low while stopped
  always @(posedge i_clk) begin
    if (!i_run) begin
      ph <= 1'b0;
      o_cclk <= 1'b0;
    end else begin
      ph <= !ph;
      if (ph) o_cclk <= !o_cclk;
      // gate moves only at a fall, so it is steady across the next rise
      if (ph && o_cclk) o_gate <= i_gate_req;
    end
  end
endmodule

`default_nettype wire

// ==== dv/ict_channel_bench.sv ====
`default_nettype none

module ict_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, hsel, hwrite, hrdy, hresp, tout, cclk, gate, run, gate_req, cclk_q;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  int          num_errors, compares, falls;

  ict_channel ict_channel_inst (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
    .O_HRDATA(hrdata), .I_CNT_CLK(cclk), .I_GATE(gate), .O_OUT(tout));
  ict_cclk_src ict_cclk_src_inst (.i_clk(clk), .i_run(run), .i_gate_req(gate_req), .o_cclk(cclk), .o_gate(gate));

  always #4 clk = ~clk;
  // falls of the count clock, seen one cycle late like the block sees them
  always @(posedge clk) begin
    cclk_q <= cclk;
    if (cclk_q && !cclk) falls <= falls + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready and read data are taken at the rising edge, before that edge's updates land
  task automatic wait_rdy;
    do begin
      @(posedge clk);
    end while (hrdy !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic prog(input logic [2:0] m, input logic b, input logic [1:0] a);
    bus(1'b1, ict_pkg::ICT_OFS_CTRL, {26'h000_0000, a, m, b});
  endtask

  task automatic cnt(input logic [7:0] v);
    bus(1'b1, ict_pkg::ICT_OFS_COUNT, {24'h00_0000, v});
  endtask

  task automatic chk_st(input logic o, input logic n, input logic [5:0] cw);
    bus(1'b0, ict_pkg::ICT_OFS_STATUS, 32'h0000_0000);
    chk(rd, {24'h00_0000, o, n, cw});
  endtask

  task automatic drive(input logic r, input logic g);
    @(posedge clk);
    run <= r;
    gate_req <= g;
  endtask

  task automatic spin(input int n);
    int s;
    s = falls;
    while (falls - s < n) @(negedge clk);
  endtask

  // count clock falls until the output reaches the given level
  task automatic falls_until(input logic lvl, output int n);
    int s, k;
    s = falls;
    k = 0;
    while (tout !== lvl && k < 3000) begin
      @(negedge clk);
      k++;
    end
    n = falls - s;
  endtask

  task automatic t_modes;
    int m;
    chk_st(1'b0, 1'b0, 6'h10);
    bus(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (m = 0; m < 6; m++) begin
      prog(3'(m), 1'b0, 2'h1);
      chk_st(m != 0, 1'b1, {2'h1, 3'(m), 1'b0});
    end
  endtask

  task automatic t_mode0;
    int n;
    prog(3'h0, 1'b0, 2'h1);
    cnt(8'h05);
    drive(1'b1, 1'b0);
    spin(8);
    chk({31'h0, tout}, 32'h0000_0000);
    drive(1'b1, 1'b1);
    falls_until(1'b1, n);
    chk(32'(n), 32'h0000_0006);
    chk_st(1'b1, 1'b0, 6'h10);
    drive(1'b0, 1'b1);
    prog(3'h0, 1'b0, 2'h3);
    cnt(8'h03);
    cnt(8'h00);
    drive(1'b1, 1'b1);
    falls_until(1'b1, n);
    chk(32'(n), 32'h0000_0004);
    drive(1'b0, 1'b1);
    cnt(8'h05);
    drive(1'b1, 1'b1);
    spin(6);
    chk({31'h0, tout}, 32'h0000_0000);
    drive(1'b0, 1'b1);
    cnt(8'h00);
    drive(1'b1, 1'b1);
    falls_until(1'b1, n);
    chk(32'(n), 32'h0000_0006);
    drive(1'b0, 1'b1);
    prog(3'h0, 1'b1, 2'h1);
    cnt(8'h10);
    drive(1'b1, 1'b1);
    falls_until(1'b1, n);
    chk(32'(n), 32'h0000_000b);
  endtask

  task automatic t_rate;
    int n, i;
    drive(1'b0, 1'b1);
    prog(3'h2, 1'b0, 2'h1);
    cnt(8'h03);
    drive(1'b1, 1'b1);
    falls_until(1'b0, n);
    falls_until(1'b1, n);
    chk(32'(n), 32'h0000_0001);
    falls_until(1'b0, n);
    chk(32'(n), 32'h0000_0002);
    // odd then even square wave
    for (i = 5; i > 3; i--) begin
      drive(1'b0, 1'b1);
      prog(3'h3, 1'b0, 2'h1);
      cnt(8'(i));
      drive(1'b1, 1'b1);
      falls_until(1'b0, n);
      falls_until(1'b1, n);
      chk(32'(n), 32'(i / 2));
      falls_until(1'b0, n);
      chk(32'(n), 32'(i - i / 2));
    end
    drive(1'b1, 1'b0);
    spin(3);
    chk({31'h0, tout}, 32'h0000_0001);
    drive(1'b1, 1'b1);
    falls_until(1'b0, n);
    chk(32'(n), 32'h0000_0004);
  endtask

  task automatic t_strobe;
    int n;
    drive(1'b0, 1'b1);
    prog(3'h4, 1'b0, 2'h1);
    cnt(8'h02);
    drive(1'b1, 1'b1);
    falls_until(1'b0, n);
    chk(32'(n), 32'h0000_0003);
    falls_until(1'b1, n);
    chk(32'(n), 32'h0000_0001);
    for (int m = 5; m > 0; m -= 4) begin
      drive(1'b1, 1'b0);
      spin(2);
      drive(1'b0, 1'b0);
      prog(3'(m), 1'b0, 2'h1);
      cnt(8'h02);
      drive(1'b1, 1'b0);
      spin(4);
      chk({31'h0, tout}, 32'h0000_0001);
      drive(1'b1, 1'b1);
      falls_until(1'b0, n);
      chk(32'(n), (m == 5) ? 32'h0000_0004 : 32'h0000_0002);
      falls_until(1'b1, n);
      chk(32'(n), (m == 5) ? 32'h0000_0001 : 32'h0000_0002);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    {run, gate_req, cclk_q} = '0;
    {num_errors, compares, falls} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_modes();
    t_mode0();
    t_rate();
    t_strobe();
    tally_and_finish();
  end

  // hang guard, well beyond the several hundred cycles the run needs
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule

`default_nettype wire

// ==== dv/ict_channel_checker.sv ====
`default_nettype none

module ict_channel_checker (
  input wire logic                           I_SYS_CLK,
  input wire logic                           I_RSTN,
  input wire logic                           I_HSEL,
  input wire logic [ict_pkg::ICT_ADDR_W-1:0] I_HADDR,
  input wire logic [1:0]                     I_HTRANS,
  input wire logic                           I_HWRITE,
  input wire logic [2:0]                     I_HSIZE,
  input wire logic [31:0]                    I_HWDATA,
  input wire logic                           I_HREADY,
  input wire logic                           O_HREADYOUT,
  input wire logic                           O_HRESP,
  input wire logic [31:0]                    O_HRDATA,
  input wire logic                           I_CNT_CLK,
  input wire logic                           I_GATE,
  input wire logic                           O_OUT
);
  logic       cclk_q;
  logic       wr_dp;
  logic [7:0] dp_addr;
  logic [2:0] cur_mode;
  logic [2:0] quiet;
  wire logic  take = I_HSEL & I_HTRANS[1] & I_HREADY;

  // shadow of the programmed mode and of the time since the last cause
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      cclk_q <= 1'b0;
      wr_dp <= 1'b0;
      dp_addr <= 8'h00;
      cur_mode <= 3'h0;
      quiet <= 3'h7;
    end else begin
      cclk_q <= I_CNT_CLK;
      if (I_HREADY) wr_dp <= take & I_HWRITE;
      if (I_HREADY) dp_addr <= I_HADDR;
      if (wr_dp && dp_addr == ict_pkg::ICT_OFS_CTRL && I_HWDATA[5:4] != 2'h0)
        cur_mode <= (I_HWDATA[3:1] > 3'h5) ? I_HWDATA[3:1] - 3'h4 : I_HWDATA[3:1];
      quiet <= (I_CNT_CLK != cclk_q || wr_dp) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
  end

  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  a_resp_okay: assert property (O_HRESP == 1'b0) else $error("response not okay");
  a_read_wait: assert property (take && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && I_HWRITE |=> O_HREADYOUT) else $error("write stalled");
  a_wait_cause: assert property (!O_HREADYOUT |-> $past(take && !I_HWRITE)) else $error("stall without read");
  a_rdata_hold: assert property ($changed(O_HRDATA) |-> $past(!O_HREADYOUT)) else $error("read data moved");
  // a limitation: for a count clock of at most eight system cycles the window never closes
  a_out_cause: assert property ($changed(O_OUT) |-> quiet < 3'h4) else $error("output moved without cause");
  a_mode_level: assert property (wr_dp && dp_addr == ict_pkg::ICT_OFS_CTRL && I_HWDATA[5:4] != 2'h0
    |-> ##[1:2] (O_OUT == (cur_mode != 3'h0))) else $error("wrong starting level");
  a_m0_write_low: assert property (wr_dp && dp_addr == ict_pkg::ICT_OFS_COUNT && cur_mode == 3'h0
    |-> ##[1:2] !O_OUT) else $error("count write left output high");
  a_m0_hold_high: assert property (cur_mode == 3'h0 && O_OUT && !wr_dp && !$past(wr_dp) |=> O_OUT)
    else $error("terminal level lost");
  a_gate_force: assert property ((cur_mode == 3'h2 || cur_mode == 3'h3) && I_CNT_CLK && !cclk_q && !I_GATE
    |-> ##[1:3] O_OUT) else $error("low gate did not force high");
  a_strobe_pulse: assert property ((cur_mode == 3'h2 || cur_mode == 3'h4 || cur_mode == 3'h5) && $fell(O_OUT)
    |-> ##[1:8] O_OUT) else $error("strobe pulse too long");
endmodule

bind ict_channel ict_channel_checker ict_channel_checker_inst (.I_SYS_CLK, .I_RSTN, .I_HSEL, .I_HADDR, .I_HTRANS,
  .I_HWRITE, .I_HSIZE, .I_HWDATA, .I_HREADY, .O_HREADYOUT, .O_HRESP, .O_HRDATA, .I_CNT_CLK, .I_GATE, .O_OUT);

`default_nettype wire

// ==== rtl/ict_channel.sv ====
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`default_nettype none

module ict_channel (
  input  wire logic                              I_SYS_CLK,
  input  wire logic                              I_RSTN,
  input  wire logic                              I_HSEL,
  input  wire logic [ict_pkg::ICT_ADDR_W-1:0]    I_HADDR,
  input  wire logic [1:0]                        I_HTRANS,
  input  wire logic                              I_HWRITE,
  input  wire logic [2:0]                        I_HSIZE,
  input  wire logic [31:0]                       I_HWDATA,
  input  wire logic                              I_HREADY,
  output logic                                   O_HREADYOUT,
  output logic                                   O_HRESP,
  output logic [31:0]                            O_HRDATA,
  input  wire logic                              I_CNT_CLK,
  input  wire logic                              I_GATE,
  output logic                                   O_OUT
);

  ict_pkg::ict_state_type st_r;
  ict_pkg::ict_state_type st_nxt;

  logic                              cclk_rise;
  logic                              cclk_fall;
  logic                              wr_data;
  logic [ict_pkg::ICT_CNT_W-1:0]     sq_load;
  logic [31:0]                       rd_mux;

  // one decimal or binary step down
  function automatic logic [15:0] cnt_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r = v - 16'h0001;
    borrow = 1'b1;
    if (bcd) begin
      r = v;
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (v[i*4 +: 4] == 4'h0) begin
            r[i*4 +: 4] = 4'h9;
          end else begin
            r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // count clock and gate are plain synchronous inputs sampled here
  assign cclk_rise = I_CNT_CLK & ~st_r.cclk_prev;
  assign cclk_fall = ~I_CNT_CLK & st_r.cclk_prev;
  assign wr_data   = st_r.ph_valid & st_r.ph_write;
  // odd counts drop their low bit so two-steps still land on two
  assign sq_load   = {st_r.hold[15:1], 1'b0};

  // read view of the registers; reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    // struct order differs from the register layout, so place each field by hand
    if (st_r.ph_addr == ict_pkg::ICT_OFS_CTRL) begin
      rd_mux[5:0] = {st_r.ctrl.rw, st_r.ctrl.mode, st_r.ctrl.bcd};
    end else if (st_r.ph_addr == ict_pkg::ICT_OFS_COUNT) begin
      rd_mux[15:0] = st_r.cnt;
    end else if (st_r.ph_addr == ict_pkg::ICT_OFS_STATUS) begin
      rd_mux[5:0] = {st_r.ctrl.rw, st_r.ctrl.mode, st_r.ctrl.bcd};
      rd_mux[ict_pkg::ICT_ST_NULL] = st_r.null_cnt;
      rd_mux[ict_pkg::ICT_ST_OUT] = st_r.out;
    end
  end

  // next state: bus slave, gate sampling, falling-edge counter, then register writes
  always_comb begin
    st_nxt = st_r;
    st_nxt.cclk_prev = I_CNT_CLK;

    // bus: writes complete with no wait; reads take one wait cycle
    st_nxt.ph_valid = 1'b0;
    st_nxt.hready = 1'b1;
    if (st_r.rd_wait) begin
      st_nxt.rd_wait = 1'b0;
      st_nxt.hrdata = rd_mux;
    end
    if (I_HSEL && I_HTRANS[1] && I_HREADY) begin
      st_nxt.ph_valid = 1'b1;
      st_nxt.ph_write = I_HWRITE;
      st_nxt.ph_addr = I_HADDR;
      if (!I_HWRITE) begin
        st_nxt.rd_wait = 1'b1;
        st_nxt.hready = 1'b0;
      end
    end

    // gate sampled on the count-clock rise
    if (cclk_rise) begin
      st_nxt.gate_s = I_GATE;
      if (I_GATE && !st_r.gate_s) begin
        st_nxt.trig = 1'b1;
      end
      if (!I_GATE && (st_r.ctrl.mode == ict_pkg::ICT_MODE_RATE ||
                      st_r.ctrl.mode == ict_pkg::ICT_MODE_SQUARE)) begin
        st_nxt.out = 1'b1;
      end
    end

    // all loading and counting on the count-clock fall
    if (cclk_fall) begin
      st_nxt.trig = 1'b0;
      unique case (st_r.ctrl.mode)
        ict_pkg::ICT_MODE_TC_INT, ict_pkg::ICT_MODE_SW_STROBE: begin
          if (st_r.ctrl.mode == ict_pkg::ICT_MODE_SW_STROBE && !st_r.out) begin
            st_nxt.out = 1'b1;
          end
          if (st_r.load_pend) begin
            st_nxt.cnt = st_r.hold;
            st_nxt.load_pend = 1'b0;
            st_nxt.null_cnt = 1'b0;
            st_nxt.counting = 1'b1;
            st_nxt.fired = 1'b0;
          end else if (st_r.counting && st_r.gate_s) begin
            st_nxt.cnt = cnt_dec(st_r.cnt, st_r.ctrl.bcd);
            if (st_r.cnt == ict_pkg::ICT_CNT_ONE && !st_r.fired) begin
              st_nxt.fired = 1'b1;
              if (st_r.ctrl.mode == ict_pkg::ICT_MODE_TC_INT) begin
                st_nxt.out = 1'b1;
              end else begin
                st_nxt.out = 1'b0;
              end
            end
          end
        end
        ict_pkg::ICT_MODE_ONESHOT, ict_pkg::ICT_MODE_HW_STROBE: begin
          if (st_r.ctrl.mode == ict_pkg::ICT_MODE_HW_STROBE && !st_r.out) begin
            st_nxt.out = 1'b1;
          end
          if (st_r.trig && st_r.hold_ok) begin
            // retrigger always restarts from the holding value
            st_nxt.cnt = st_r.hold;
            st_nxt.null_cnt = 1'b0;
            st_nxt.counting = 1'b1;
            st_nxt.fired = 1'b0;
            if (st_r.ctrl.mode == ict_pkg::ICT_MODE_ONESHOT) begin
              st_nxt.out = 1'b0;
            end
          end else if (st_r.counting) begin
            st_nxt.cnt = cnt_dec(st_r.cnt, st_r.ctrl.bcd);
            if (st_r.cnt == ict_pkg::ICT_CNT_ONE && !st_r.fired) begin
              st_nxt.fired = 1'b1;
              if (st_r.ctrl.mode == ict_pkg::ICT_MODE_ONESHOT) begin
                st_nxt.out = 1'b1;
              end else begin
                st_nxt.out = 1'b0;
              end
            end
          end
        end
        ict_pkg::ICT_MODE_RATE, ict_pkg::ICT_MODE_SQUARE: begin
          if ((st_r.load_pend || st_r.trig) && st_r.hold_ok) begin
            // first load or gate re-sync starts a fresh period
            if (st_r.ctrl.mode == ict_pkg::ICT_MODE_SQUARE) begin
              st_nxt.cnt = sq_load;
            end else begin
              st_nxt.cnt = st_r.hold;
            end
            st_nxt.out = 1'b1;
            st_nxt.sq_extra = 1'b0;
            st_nxt.null_cnt = 1'b0;
            st_nxt.load_pend = 1'b0;
            st_nxt.counting = 1'b1;
          end else if (st_r.counting && st_r.gate_s && st_r.ctrl.mode == ict_pkg::ICT_MODE_RATE) begin
            if (st_r.cnt == ict_pkg::ICT_CNT_ONE) begin
              // reload picks up any count written during the period
              st_nxt.cnt = st_r.hold;
              st_nxt.null_cnt = 1'b0;
              st_nxt.out = 1'b1;
            end else begin
              st_nxt.cnt = cnt_dec(st_r.cnt, st_r.ctrl.bcd);
              if (st_r.cnt == ict_pkg::ICT_CNT_TWO) begin
                st_nxt.out = 1'b0;
              end
            end
          end else if (st_r.counting && st_r.gate_s) begin
            if (st_r.sq_extra) begin
              // odd count: low half starts one pulse late
              st_nxt.sq_extra = 1'b0;
              st_nxt.out = 1'b0;
              st_nxt.cnt = sq_load;
              st_nxt.null_cnt = 1'b0;
            end else if (st_r.cnt == ict_pkg::ICT_CNT_TWO) begin
              if (st_r.out && st_r.hold[0]) begin
                st_nxt.sq_extra = 1'b1;
                st_nxt.cnt = cnt_dec(cnt_dec(st_r.cnt, st_r.ctrl.bcd), st_r.ctrl.bcd);
              end else begin
                st_nxt.out = ~st_r.out;
                st_nxt.cnt = sq_load;
                st_nxt.null_cnt = 1'b0;
              end
            end else begin
              st_nxt.cnt = cnt_dec(cnt_dec(st_r.cnt, st_r.ctrl.bcd), st_r.ctrl.bcd);
            end
          end
        end
        default: begin
          st_nxt.counting = 1'b0;
        end
      endcase
    end

    // register writes land last so a write beats a same-cycle load
    if (wr_data && st_r.ph_addr == ict_pkg::ICT_OFS_CTRL &&
        I_HWDATA[ict_pkg::ICT_CW_RW_L +: 2] != ict_pkg::ICT_RW_LATCH) begin
      st_nxt.ctrl.bcd = I_HWDATA[ict_pkg::ICT_CW_BCD];
      st_nxt.ctrl.rw = I_HWDATA[ict_pkg::ICT_CW_RW_L +: 2];
      // codes 6 and 7 fold onto the two periodic modes
      st_nxt.ctrl.mode = ict_pkg::ict_mode_type'(
        I_HWDATA[ict_pkg::ICT_CW_MODE_L + 1] ?
        {1'b0, I_HWDATA[ict_pkg::ICT_CW_MODE_L +: 2]} : I_HWDATA[ict_pkg::ICT_CW_MODE_L +: 3]);
      st_nxt.lsb_wait = 1'b0;
      st_nxt.hold_ok = 1'b0;
      st_nxt.null_cnt = 1'b1;
      st_nxt.load_pend = 1'b0;
      st_nxt.counting = 1'b0;
      st_nxt.trig = 1'b0;
      st_nxt.fired = 1'b0;
      st_nxt.sq_extra = 1'b0;
      st_nxt.out = (I_HWDATA[ict_pkg::ICT_CW_MODE_L +: 3] != 3'h0);
    end else if (wr_data && st_r.ph_addr == ict_pkg::ICT_OFS_COUNT) begin
      if (st_r.ctrl.rw == ict_pkg::ICT_RW_LSB) begin
        st_nxt.hold = {8'h00, I_HWDATA[7:0]};
      end else if (st_r.ctrl.rw == ict_pkg::ICT_RW_MSB) begin
        st_nxt.hold = {I_HWDATA[7:0], 8'h00};
      end else if (!st_r.lsb_wait) begin
        st_nxt.hold = {st_r.hold[15:8], I_HWDATA[7:0]};
        st_nxt.lsb_wait = 1'b1;
      end else begin
        st_nxt.hold = {I_HWDATA[7:0], st_r.hold[7:0]};
        st_nxt.lsb_wait = 1'b0;
      end
      if (st_r.ctrl.rw == 2'b11 && !st_r.lsb_wait) begin
        // first byte only: mode 0 halts, other modes keep counting
        if (st_r.ctrl.mode == ict_pkg::ICT_MODE_TC_INT) begin
          st_nxt.counting = 1'b0;
          st_nxt.load_pend = 1'b0;
          st_nxt.out = 1'b0;
        end
      end else begin
        st_nxt.hold_ok = 1'b1;
        st_nxt.null_cnt = 1'b1;
        unique case (st_r.ctrl.mode)
          ict_pkg::ICT_MODE_TC_INT: begin
            st_nxt.load_pend = 1'b1;
            st_nxt.counting = 1'b0;
            st_nxt.out = 1'b0;
          end
          ict_pkg::ICT_MODE_SW_STROBE: begin
            st_nxt.load_pend = 1'b1;
          end
          ict_pkg::ICT_MODE_RATE, ict_pkg::ICT_MODE_SQUARE: begin
            // running periods keep their value until the next reload
            st_nxt.load_pend = ~st_r.counting;
          end
          ict_pkg::ICT_MODE_ONESHOT, ict_pkg::ICT_MODE_HW_STROBE: begin
            st_nxt.load_pend = 1'b0;
          end
          default: begin
            st_nxt.load_pend = 1'b0;
          end
        endcase
      end
    end
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      st_r <= ict_pkg::ICT_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_HREADYOUT = st_r.hready;
  assign O_HRESP     = 1'b0;         // always OKAY
  assign O_HRDATA    = st_r.hrdata;
  assign O_OUT       = st_r.out;

endmodule

`default_nettype wire

// ==== shared/ict_pkg.sv ====
// Notes on behaviour
// - programming a mode drives the output to that mode's starting level at once.
// - gate sampled on count-clock rise; level, edge or both depending on mode.
// - down-counter loads and decrements only on count-clock falling edges.
// - count zero means the largest count, 65536 binary or 10000 decimal.
// - modes 0,1,4,5 wrap past zero; modes 2,3 reload and repeat.
// - mode 0 output low until terminal count, then high until rewritten.
// - mode 0 gate high counts, gate low pauses; output ignores gate.
// - mode 0 new count enters down-counter on the next count-clock pulse.
// - mode 0 first of two bytes halts and drives low; second byte reloads.
// - mode 1 output high; trigger loads, drives low next pulse, high at terminal.
// - mode 1 retrigger restarts full count; new count waits for next trigger.
// - mode 2 output low one pulse at count 1, then reload and high.
// - modes 2,3 gate low stops and forces high; gate rise reloads next pulse.
// - mode 2 new count used from the following period onward.
// - mode 3 even count steps by two, toggles and reloads at terminal.
// - mode 3 odd count loads N-1, high (N+1)/2 and low (N-1)/2.
// - mode 4 high on programming; loads next pulse; one low pulse at terminal.
// - mode 4 gate pauses or allows counting, never touches the output.
// - mode 4 new count loads next pulse; first of two bytes changes nothing.
// - mode 5 high; gate rise loads next pulse; retrigger restarts; one low pulse.
// - mode 5 new count waits until the pulse after the next trigger.
// - pending-count flag set by mode or count write, cleared on transfer.
`default_nettype none

package ict_pkg;

  localparam int ICT_ADDR_W = 8;
  localparam int ICT_CNT_W  = 16;

  // register byte offsets
  localparam logic [ICT_ADDR_W-1:0] ICT_OFS_CTRL   = 8'h00;
  localparam logic [ICT_ADDR_W-1:0] ICT_OFS_COUNT  = 8'h04;
  localparam logic [ICT_ADDR_W-1:0] ICT_OFS_STATUS = 8'h08;

  // control word fields, same layout as the low status bits
  localparam int ICT_CW_BCD    = 0;
  localparam int ICT_CW_MODE_L = 1;
  localparam int ICT_CW_RW_L   = 4;
  localparam int ICT_ST_NULL   = 6;
  localparam int ICT_ST_OUT    = 7;

  // byte access codes
  localparam logic [1:0] ICT_RW_LATCH = 2'b00;
  localparam logic [1:0] ICT_RW_LSB   = 2'b01;
  localparam logic [1:0] ICT_RW_MSB   = 2'b10;

  localparam logic [ICT_CNT_W-1:0] ICT_CNT_ONE = 16'h0001;
  localparam logic [ICT_CNT_W-1:0] ICT_CNT_TWO = 16'h0002;

  typedef enum logic [2:0] {
    ICT_MODE_TC_INT,
    ICT_MODE_ONESHOT,
    ICT_MODE_RATE,
    ICT_MODE_SQUARE,
    ICT_MODE_SW_STROBE,
    ICT_MODE_HW_STROBE
  } ict_mode_type;

  typedef struct packed {
    ict_mode_type mode;
    logic         bcd;
    logic [1:0]   rw;
  } ict_ctrl_type;

  typedef struct packed {
    ict_ctrl_type          ctrl;
    logic [ICT_CNT_W-1:0]  hold;       // holding count register
    logic [ICT_CNT_W-1:0]  cnt;        // down-counter
    logic                  lsb_wait;   // first of two bytes seen
    logic                  hold_ok;    // a complete count exists
    logic                  null_cnt;
    logic                  load_pend;
    logic                  trig;
    logic                  gate_s;
    logic                  counting;
    logic                  fired;
    logic                  sq_extra;
    logic                  out;
    logic                  cclk_prev;
    logic                  ph_valid;
    logic                  ph_write;
    logic [ICT_ADDR_W-1:0] ph_addr;
    logic                  rd_wait;
    logic                  hready;
    logic [31:0]           hrdata;
  } ict_state_type;

  localparam ict_state_type ICT_STATE_RST = '{
    ctrl:     '{mode: ICT_MODE_TC_INT, bcd: 1'b0, rw: ICT_RW_LSB},
    hold:     16'h0000,
    cnt:      16'h0000,
    hready:   1'b1,
    hrdata:   32'h0000_0000,
    ph_addr:  8'h00,
    default:  1'b0
  };

endpackage

`default_nettype wire
